// ### src/eba_pkg.sv
// Package with types and constants for the external bus access arbiter
package eba_pkg;
	// Requester indices in decreasing priority
	localparam int unsigned REQ_PANIC = 0;
	localparam int unsigned REQ_DMA0  = 1;
	localparam int unsigned REQ_DMA1  = 2;
	localparam int unsigned REQ_EXT   = 3;
	localparam int unsigned REQ_DATA  = 4;
	localparam int unsigned REQ_INSTR = 5;
	localparam int unsigned NUM_REQ   = 6;
	localparam int unsigned NUM_CH    = 2;
	localparam int unsigned NUM_RGN   = 6;

	// Access widths and memory widths
	localparam logic [1:0] WID_32 = 2'h0;
	localparam logic [1:0] WID_8  = 2'h1;
	localparam logic [1:0] WID_16 = 2'h2;

	// Last beat index for narrow splits
	localparam logic [1:0] BEATS_ONE  = 2'h0;
	localparam logic [1:0] BEATS_TWO  = 2'h1;
	localparam logic [1:0] BEATS_FOUR = 2'h3;

	// Region selects driven by each DMA channel
	localparam int unsigned DMA0_RGN = 0;
	localparam int unsigned DMA1_RGN = 1;

	// Arbiter states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_READ  = 4'h2,
		ST_WRITE = 4'h4,
		ST_BEAT  = 4'h8
	} eba_state_e;

	// Per-channel DMA setup
	typedef struct packed {
		logic enable;     // Channel is active
		logic external;   // Uses request/acknowledge pins
		logic edge_mode;  // Request is edge-sensitive
		logic active_hi;  // Request polarity (high or rising)
		logic use_rgn;    // Drive the channel's region select
		logic rd_periph;  // Read side is the peripheral
	} eba_dma_cfg_s;

	// Processor access request
	typedef struct packed {
		logic       req;      // Access wanted
		logic       write;    // Write access
		logic       periph;   // Peripheral target
		logic [2:0] rgn;      // Peripheral region number
		logic [1:0] mem_wid;  // Target memory width
	} eba_cpu_req_s;
endpackage

// ### src/eba_arbiter.sv
// External bus access arbiter with DMA, external master and PIA strobes
// Behaviour
// - Priority: panic refresh, DMA0, DMA1, ext, data, instr
// - DMA read then write, nothing between
// - Narrow accesses split into back-to-back beats
// - Normal refresh only when bus idle
// - DMA request level/edge, either polarity
// - DMA acknowledge during external channel transfer
// - On-chip DMA uses no request/acknowledge
// - Terminate input pulses done after the DMA write access
// - Grant acknowledge when external master granted
// - DMA channels may drive region selects 0/1
// - Output enable during peripheral read
// - Write enable during peripheral write
// - Wait input extends the current access
// - Direction high for read, low for write
`timescale 1ns/1ns
module eba_arbiter #(
	parameter int unsigned NCH = eba_pkg::NUM_CH
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic                       panic_refresh_req,
	input  wire logic                       normal_refresh_req,
	input  wire logic [NCH-1:0]             dma_channel_request,
	input  wire logic [NCH-1:0]             dma_internal_req,
	input  wire eba_pkg::eba_dma_cfg_s [NCH-1:0] dma_cfg,
	input  wire logic                       dma_terminate_in,
	input  wire logic                       external_master_request_n,
	input  wire eba_pkg::eba_cpu_req_s      cpu_data,
	input  wire eba_pkg::eba_cpu_req_s      cpu_instr,
	input  wire logic                       wait_n,
	output logic [NCH-1:0]                  dma_channel_acknowledge,
	output logic                            external_master_grant,
	output logic [eba_pkg::NUM_RGN-1:0]     peripheral_region_select,
	output logic                            peripheral_output_enable,
	output logic                            peripheral_write_enable,
	output logic                            read_not_write,
	output logic [eba_pkg::NUM_REQ-1:0]     grant_ff,
	output logic                            refresh_go_ff,
	output logic                            dma_done_ff
);
	eba_pkg::eba_state_e              state_ff;     // Sequence state
	eba_pkg::eba_state_e              nxt_state;    // Next state
	logic [eba_pkg::NUM_REQ-1:0]      req_vec;      // Pending requests
	logic [eba_pkg::NUM_REQ-1:0]      nxt_grant;    // Winner one-hot
	logic [NCH-1:0]                   dreq_prev_ff; // Last request level
	logic [NCH-1:0]                   dreq_pend_ff; // Latched edge request
	logic [NCH-1:0]                   dreq_act;     // Active request
	logic [1:0]                       beat_ff;      // Beat counter
	logic [1:0]                       beats_ff;     // Last beat index
	logic [1:0]                       nxt_beats;    // Beats for winner
	logic                             stretch;      // Wait held
	logic                             dma_sel;      // DMA channel 1 won
	logic                             dma_win;      // Some DMA won
	eba_pkg::eba_cpu_req_s            cpu_sel;      // Chosen CPU access
	eba_pkg::eba_cpu_req_s            cpu_ff;       // Held CPU access

	assign stretch = !wait_n;

	// Request qualification per channel
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			if (!dma_cfg[i].enable) begin
				dreq_act[i] = 1'b0;
			end else if (!dma_cfg[i].external) begin
				dreq_act[i] = dma_internal_req[i];
			end else if (dma_cfg[i].edge_mode) begin
				dreq_act[i] = dreq_pend_ff[i];
			end else begin
				dreq_act[i] = dma_channel_request[i] ==
					dma_cfg[i].active_hi;
			end
		end
	end

	// Edge detection for edge-sensitive requests
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dreq_prev_ff <= '1; // Pins idle high on pull-ups
			dreq_pend_ff <= '0;
		end else begin
			dreq_prev_ff <= dma_channel_request;
			for (int i = 0; i < NCH; i++) begin
				// Set wins over grant clear; level mode keeps none
				if (dma_channel_request[i] != dreq_prev_ff[i] &&
					dma_channel_request[i] == dma_cfg[i].active_hi) begin
					dreq_pend_ff[i] <= dma_cfg[i].edge_mode;
				end else if (!dma_cfg[i].edge_mode ||
					(state_ff == eba_pkg::ST_IDLE &&
					nxt_grant[eba_pkg::REQ_DMA0 + i])) begin
					dreq_pend_ff[i] <= 1'b0;
				end
			end
		end
	end

	// Request vector in priority order
	always_comb begin
		req_vec = '0;
		req_vec[eba_pkg::REQ_PANIC] = panic_refresh_req;
		req_vec[eba_pkg::REQ_DMA0]  = dreq_act[0];
		req_vec[eba_pkg::REQ_DMA1]  = dreq_act[1];
		req_vec[eba_pkg::REQ_EXT]   = !external_master_request_n;
		req_vec[eba_pkg::REQ_DATA]  = cpu_data.req;
		req_vec[eba_pkg::REQ_INSTR] = cpu_instr.req;
	end

	// Fixed priority pick, lowest index wins
	always_comb begin
		nxt_grant = '0;
		for (int i = eba_pkg::NUM_REQ - 1; i >= 0; i--) begin
			if (req_vec[i]) begin
				nxt_grant = '0;
				nxt_grant[i] = 1'b1;
			end
		end
		cpu_sel = nxt_grant[eba_pkg::REQ_DATA] ? cpu_data : cpu_instr;
		nxt_beats = eba_pkg::BEATS_ONE;
		if (|nxt_grant[eba_pkg::REQ_INSTR:eba_pkg::REQ_DATA]) begin
			unique case (cpu_sel.mem_wid)
				eba_pkg::WID_8:  nxt_beats = eba_pkg::BEATS_FOUR;
				eba_pkg::WID_16: nxt_beats = eba_pkg::BEATS_TWO;
				default:         nxt_beats = eba_pkg::BEATS_ONE;
			endcase
		end
	end

	assign dma_win = |grant_ff[eba_pkg::REQ_DMA1:eba_pkg::REQ_DMA0];
	assign dma_sel = grant_ff[eba_pkg::REQ_DMA1];

	// Next-state logic
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			eba_pkg::ST_IDLE: begin
				if (|nxt_grant[eba_pkg::REQ_DMA1:eba_pkg::REQ_DMA0]) begin
					nxt_state = eba_pkg::ST_READ;
				end else if (|nxt_grant) begin
					nxt_state = eba_pkg::ST_BEAT;
				end
			end
			eba_pkg::ST_READ: begin
				if (!stretch) begin
					nxt_state = eba_pkg::ST_WRITE;
				end
			end
			eba_pkg::ST_WRITE: begin
				if (!stretch) begin
					nxt_state = eba_pkg::ST_IDLE;
				end
			end
			eba_pkg::ST_BEAT: begin
				if (grant_ff[eba_pkg::REQ_EXT]) begin
					if (external_master_request_n) begin
						nxt_state = eba_pkg::ST_IDLE;
					end
				end else if (!stretch && beat_ff == beats_ff) begin
					nxt_state = eba_pkg::ST_IDLE;
				end
			end
			default: nxt_state = eba_pkg::ST_IDLE;
		endcase
	end

	// State, grant and beat bookkeeping
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= eba_pkg::ST_IDLE;
			grant_ff <= '0;
			beat_ff  <= '0;
			beats_ff <= '0;
			cpu_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == eba_pkg::ST_IDLE) begin
				grant_ff <= nxt_grant;
				beats_ff <= nxt_beats;
				beat_ff  <= '0;
				cpu_ff   <= cpu_sel;
			end else if (nxt_state == eba_pkg::ST_IDLE) begin
				grant_ff <= '0;
			end else if (state_ff == eba_pkg::ST_BEAT && !stretch) begin
				beat_ff <= beat_ff + 2'h1;
			end
		end
	end

	// Terminate sample at write end and done pulse
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dma_done_ff <= 1'b0;
		end else begin
			dma_done_ff <= dma_win && state_ff == eba_pkg::ST_WRITE &&
				!stretch && dma_terminate_in;
		end
	end

	// Hidden refresh only when nothing else owns the bus
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			refresh_go_ff <= 1'b0;
		end else begin
			refresh_go_ff <= normal_refresh_req &&
				state_ff == eba_pkg::ST_IDLE && !(|nxt_grant);
		end
	end

	// Registered pin strobes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dma_channel_acknowledge  <= '0;
			external_master_grant    <= 1'b0;
			peripheral_region_select <= '0;
			peripheral_output_enable <= 1'b0;
			peripheral_write_enable  <= 1'b0;
			read_not_write           <= 1'b1;
		end else begin
			dma_channel_acknowledge  <= '0;
			peripheral_region_select <= '0;
			peripheral_output_enable <= 1'b0;
			peripheral_write_enable  <= 1'b0;
			read_not_write           <= 1'b1;
			external_master_grant    <= nxt_state == eba_pkg::ST_BEAT &&
				(state_ff == eba_pkg::ST_IDLE ?
				nxt_grant[eba_pkg::REQ_EXT] :
				grant_ff[eba_pkg::REQ_EXT]);
			if (dma_win && state_ff != eba_pkg::ST_IDLE) begin
				if (dma_cfg[dma_sel].external) begin
					dma_channel_acknowledge[dma_sel] <= 1'b1;
				end
				// Read phase high, write phase low
				read_not_write <= state_ff == eba_pkg::ST_READ;
				if (dma_cfg[dma_sel].use_rgn &&
					(state_ff == eba_pkg::ST_READ) ==
					dma_cfg[dma_sel].rd_periph) begin
					peripheral_region_select[dma_sel ?
						eba_pkg::DMA1_RGN : eba_pkg::DMA0_RGN] <= 1'b1;
					peripheral_output_enable <=
						state_ff == eba_pkg::ST_READ;
					peripheral_write_enable <=
						state_ff == eba_pkg::ST_WRITE;
				end
			end else if (state_ff == eba_pkg::ST_BEAT &&
				!grant_ff[eba_pkg::REQ_EXT] &&
				!grant_ff[eba_pkg::REQ_PANIC]) begin
				read_not_write <= !cpu_ff.write;
				if (cpu_ff.periph) begin
					peripheral_region_select[cpu_ff.rgn] <= 1'b1;
					peripheral_output_enable <= !cpu_ff.write;
					peripheral_write_enable  <= cpu_ff.write;
				end
			end
		end
	end

	// Never two grants at once
	a_grant_onehot: assert property (@(posedge ref_clk) disable iff (rst)
		$onehot0(grant_ff))
		else $error("more than one grant");
	// Read phase always followed by write
	a_dma_pair: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == eba_pkg::ST_READ && !stretch |=>
		state_ff == eba_pkg::ST_WRITE && $stable(grant_ff))
		else $error("dma read not followed by write");
	// Grant kept while beats remain
	a_beats_hold: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == eba_pkg::ST_BEAT && beat_ff != beats_ff &&
		!grant_ff[eba_pkg::REQ_EXT] |=> $stable(grant_ff))
		else $error("narrow split interrupted");
	// Refresh only while idle
	a_refresh_idle: assert property (@(posedge ref_clk) disable iff (rst)
		refresh_go_ff |-> $past(state_ff) == eba_pkg::ST_IDLE)
		else $error("refresh issued during access");
	// Internal channel 0 never acknowledged
	a_ack_internal: assert property (@(posedge ref_clk) disable iff (rst)
		dma_channel_acknowledge[0] |-> dma_cfg[0].external)
		else $error("ack on internal dma");
	// Output enable and write enable exclusive
	a_oe_we_excl: assert property (@(posedge ref_clk) disable iff (rst)
		!(peripheral_output_enable && peripheral_write_enable))
		else $error("oe and we together");
	// Write enable only with write direction
	a_we_dir: assert property (@(posedge ref_clk) disable iff (rst)
		peripheral_write_enable |-> !read_not_write)
		else $error("we with read direction");
	// Wait holds the state
	a_wait_hold: assert property (@(posedge ref_clk) disable iff (rst)
		stretch && (state_ff == eba_pkg::ST_READ ||
		state_ff == eba_pkg::ST_WRITE) |=> $stable(state_ff))
		else $error("wait ignored");
	// Grant acknowledge follows external win
	a_ext_grant: assert property (@(posedge ref_clk) disable iff (rst)
		state_ff == eba_pkg::ST_IDLE && nxt_grant[eba_pkg::REQ_EXT] |=>
		external_master_grant)
		else $error("no grant acknowledge");
endmodule

// ### sim/eba_far_end.sv
// Far-end model: external DMA devices and external bus master
`timescale 1ns/1ns
module eba_far_end (
	input  wire logic       rst,      // Reset
	input  wire logic [1:0] want_dma, // Transfer wanted per channel
	input  wire logic       want_ext, // Master wants the bus
	input  wire logic [1:0] ack,      // Acknowledge to device
	output logic      [1:0] dreq,     // Level request, active high
	output logic            mreq_n    // Grant request, active low
);
	// Request withdrawn once the transfer is acknowledged
	assign dreq = want_dma & ~ack;
	// Held high in reset; asks, then holds while the master wants the bus
	assign mreq_n = rst | ~want_ext;
endmodule

// ### sim/eba_arbiter_test.sv
// Self-checking bench for the external bus access arbiter
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
	end end
module eba_arbiter_test;
	logic                  ref_clk = 1'b0;   // Bench clock
	logic                  rst = 1'b1;       // Reset
	logic                  prf = 1'b0;       // Panic refresh
	logic                  nrf = 1'b0;       // Normal refresh
	logic                  term = 1'b0;      // Terminate
	logic                  wait_n = 1'b1;    // Wait, active low
	logic                  want_ext = 1'b0;  // Master wants bus
	logic                  mrq_n;            // Master request
	logic [1:0]            want = 2'h0;      // DMA wanted
	logic [1:0]            inv = 2'h0;       // Request inversion
	logic [1:0]            ireq = 2'h0;      // On-chip DMA
	logic [1:0]            dreq, ack, seen;  // DMA lines
	logic                  gnt, oe, we, rnw; // Strobes
	logic                  rgo, done;        // Pulses
	logic [5:0]            rgn, own, rs;     // Selects and owner
	logic [5:0]            last = 6'h00;     // Owner seen before
	logic [5:0]            nx;               // Popped note
	logic [5:0]            expq[$];          // Expected owners
	eba_pkg::eba_dma_cfg_s [1:0] cfg = 12'hDB6; // Level, high, external
	eba_pkg::eba_cpu_req_s cd = '0;          // Data request
	eba_pkg::eba_cpu_req_s ci = '0;          // Instruction request
	logic [1:0]            wids[4] = '{2'h1, 2'h2, 2'h0, 2'h0}; // Widths
	int                    bt[3] = '{4, 2, 1}; // Beats per width
	int                    fail_count = 0, comparisons = 0;
	int                    seed = 7845, cyc = 0, n, cnt;

	eba_far_end i_eba_far_end (.rst(rst), .want_dma(want),
		.want_ext(want_ext), .ack(ack), .dreq(dreq), .mreq_n(mrq_n));
	eba_arbiter i_eba_arbiter (.ref_clk(ref_clk), .rst(rst),
		.panic_refresh_req(prf), .normal_refresh_req(nrf),
		.dma_channel_request(dreq ^ inv), .dma_internal_req(ireq),
		.dma_cfg(cfg), .dma_terminate_in(term),
		.external_master_request_n(mrq_n), .cpu_data(cd), .cpu_instr(ci),
		.wait_n(wait_n), .dma_channel_acknowledge(ack),
		.external_master_grant(gnt), .peripheral_region_select(rgn),
		.peripheral_output_enable(oe), .peripheral_write_enable(we),
		.read_not_write(rnw), .grant_ff(own), .refresh_go_ff(rgo),
		.dma_done_ff(done));

	// Clock, 40 ns period
	always #20 ref_clk = ~ref_clk;
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end
	// Each new owner takes the oldest note
	always @(negedge ref_clk) begin
		if (own !== last && own !== 6'h00) begin
			nx = expq.size() ? expq.pop_front() : 6'h3F;
			`CHK(own, nx)
		end
		last = own;
	end

	task automatic tick();
		@(negedge ref_clk);
	endtask
	// Bounded wait for an owner to appear or to go
	task automatic wt(input bit on);
		n = 0;
		while ((own !== 6'h00) != on && n < 60) begin
			tick();
			n++;
		end
	endtask
	// Requests from index k down in priority
	task automatic reqs(input int k, input bit on);
		prf = on && k == 0;
		want = {on && k <= 2, on && k <= 1};
		want_ext = on && k <= 3;
		cd.req = on && k <= 4;
		ci.req = on;
		nrf = on;
		ireq = {2{on}};
	endtask
	// Counts and verdict
	task automatic summarize();
		`CHK(expq.size(), 0)
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (8) tick();
		rst = 1'b0;
		tick();
		for (int k = 0; k < 6; k++) begin
			expq.push_back(6'h01 << k);
			reqs(k, 1'b1);
			wt(1'b1);
			reqs(k, 1'b0);
			wt(1'b0);
		end
		$display("test priority done");
		for (int c = 0; c < 2; c++) begin
			cfg[c].rd_periph = c == 0;
			expq.push_back(6'h02 << c);
			want[c] = 1'b1;
			wt(1'b1);
			want[c] = 1'b0;
			n = 0;
			while (ack[c] !== 1'b1 && n < 9) begin
				tick();
				n++;
			end
			`CHK({rnw, oe, we, rgn}, {1'b1, c == 0, 1'b0, 6'(c == 0)})
			tick();
			`CHK({ack[c], rnw, oe, we, rgn}, {3'h4, c == 1, 6'(c == 1) << 1})
			tick();
			`CHK(ack, 2'h0)
			wt(1'b0);
		end
		$display("test walk done");
		cfg[1].edge_mode = 1'b1;
		cfg[1].active_hi = 1'b0;
		inv[1] = 1'b1;
		repeat (2) tick();
		expq.push_back(6'h04);
		want[1] = 1'b1;
		tick();
		want[1] = 1'b0;
		wt(1'b1);
		wt(1'b0);
		cfg[1] = 6'h36;
		inv[1] = 1'b0;
		cfg[0].external = 1'b0;
		expq.push_back(6'h02);
		ireq[0] = 1'b1;
		wt(1'b1);
		ireq[0] = 1'b0;
		seen = 2'h0;
		for (int i = 0; i < 5; i++) begin
			tick();
			seen |= ack;
		end
		`CHK(seen, 2'h0)
		wt(1'b0);
		cfg[0].external = 1'b1;
		expq.push_back(6'h02);
		want[0] = 1'b1;
		wt(1'b1);
		want[0] = 1'b0;
		term = 1'b1;
		cnt = 0;
		for (int i = 0; i < 6; i++) begin
			tick();
			cnt += done;
		end
		term = 1'b0;
		`CHK(cnt, 1)
		wt(1'b0);
		$display("test dma modes done");
		for (int w = 0; w < 4; w++) begin
			cd = '0;
			cd.write = 1'($random(seed));
			cd.rgn = 3'($unsigned($random(seed)) % 6);
			cd.mem_wid = wids[w];
			cd.periph = 1'b1;
			cd.req = 1'b1;
			ci.req = 1'b1;
			expq.push_back(6'h10);
			expq.push_back(6'h20);
			wt(1'b1);
			cd.req = 1'b0;
			cnt = 0;
			rs = 6'h00;
			for (int i = 0; i < 14; i++) begin
				wait_n = w < 3 || i > 2;
				tick();
				if (own === 6'h20)
					ci.req = 1'b0;
				cnt += cd.write ? we : oe;
				rs |= (oe | we) ? rgn : 6'h00;
			end
			`CHK(w < 3 ? cnt == bt[w] : cnt > 1, 1'b1)
			`CHK(rs, 6'h01 << cd.rgn)
			wt(1'b0);
		end
		$display("test cpu done");
		expq.push_back(6'h08);
		want_ext = 1'b1;
		wt(1'b1);
		nrf = 1'b1;
		cnt = 0;
		for (int i = 0; i < 3; i++) begin
			tick();
			cnt += rgo;
		end
		`CHK({gnt, own, cnt}, {7'h48, 32'h0})
		want_ext = 1'b0;
		cnt = 0;
		for (int i = 0; i < 6; i++) begin
			tick();
			cnt += rgo;
		end
		nrf = 1'b0;
		`CHK({gnt, cnt > 0}, 2'h1)
		$display("test master done");
		repeat (4) tick();
		summarize();
	end
endmodule
